// ### rtl/uart_chan.sv
`timescale 1ns/100ps
module uart_chan
  import uart_chan_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        serial_in_i,
  input  wire logic        clear_send_n_i,
  input  wire logic        set_ready_n_i,
  input  wire logic        ring_n_i,
  input  wire logic        carrier_n_i,
  output logic             serial_out_ch1_o,
  output logic             request_send_n_o,
  output logic             terminal_ready_n_o,
  output logic             user_output_one_n_o,
  output logic             user_output_two_n_o,
  output logic             baud_out_o,
  output logic             channel_interrupt_o
);

  // Bus decode
  logic       ack_q;
  logic       req;
  logic [3:0] idx;
  logic       wr;
  logic       rd;
  logic [7:0] wdat;
  logic [7:0] ier_q, lcr_q, mcr_q, scr_q, fcr_q;
  logic       hs_q;
  logic       divisor_access_bit;

  assign req  = wb_cyc_i & wb_stb_i & ~ack_q;
  assign idx  = wb_adr_i[5:2];
  assign wr   = req & wb_we_i & wb_sel_i[0];
  assign rd   = req & ~wb_we_i;
  assign wdat = wb_dat_i[7:0];
  assign divisor_access_bit = lcr_q[LCR_DIVISOR_ACCESS_BIT_BIT];

  logic wr_div_lo, wr_div_hi, wr_thr, rd_rbr, rd_iir, rd_lsr, rd_msr, wr_fcr;
  assign wr_div_lo = wr & (idx == REG_DATA) & divisor_access_bit;
  assign wr_div_hi = wr & (idx == REG_IER) & divisor_access_bit;
  assign wr_thr    = wr & (idx == REG_DATA) & ~divisor_access_bit;
  assign rd_rbr    = rd & (idx == REG_DATA) & ~divisor_access_bit;
  assign rd_iir    = rd & (idx == REG_IIR_FCR);
  assign rd_lsr    = rd & (idx == REG_LSR);
  assign rd_msr    = rd & (idx == REG_MSR);
  assign wr_fcr    = wr & (idx == REG_IIR_FCR);

  // Input synchronisers: serial in and the four modem inputs
  logic [4:0] sync1_q, sync2_q;
  always_ff @(posedge clk_i) begin
    sync1_q <= {carrier_n_i, ring_n_i, set_ready_n_i, clear_send_n_i, serial_in_i};
    sync2_q <= sync1_q;
  end

  // Oscillator enable: fractional accumulator at four times 1.8462 MHz
  logic [ACC_W-1:0] acc_q;
  logic [1:0]       ph_q;
  logic             tick4;
  assign tick4 = (acc_q >= ACC_MOD - ACC_INC);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= '0;
      ph_q  <= 2'h0;
    end else begin
      acc_q <= tick4 ? acc_q + ACC_INC - ACC_MOD : acc_q + ACC_INC;
      if (tick4) ph_q <= ph_q + 2'h1;
    end
  end

  // Baud generator
  logic [15:0] div_q, deff, reload, bcnt_q;
  logic        step, osc, brg_q, tick16, brg_low;
  assign osc    = ph_q[1];
  // High-speed mode steps four times faster and drops divisor bit 15
  assign deff   = (hs_q & div_q[15]) ? {1'b0, div_q[14:0]} : div_q;
  assign step   = (hs_q & div_q[15]) ? tick4 : (tick4 & (ph_q == 2'h3));
  assign reload = (deff == 16'h0000) ? 16'h0003 : deff;
  assign tick16 = step & (bcnt_q == 16'h0001);
  always_comb begin
    if (deff == 16'h0001) brg_low = osc;
    else if (deff == 16'h0002) brg_low = (bcnt_q == 16'h0002);
    else brg_low = (bcnt_q >= reload - 16'h0001);
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q  <= '0;
      bcnt_q <= 16'h0003;
      brg_q  <= 1'b1;
    end else begin
      if (wr_div_lo) div_q[7:0] <= wdat;
      if (wr_div_hi) div_q[15:8] <= wdat;
      if (wr_div_lo | wr_div_hi) bcnt_q <= 16'h0001;
      else if (step) bcnt_q <= (bcnt_q <= 16'h0001) ? reload : bcnt_q - 16'h0001;
      brg_q <= ~brg_low;
    end
  end
  assign baud_out_o = brg_q;

  // Control registers
  logic fifo_en;
  assign fifo_en = fcr_q[FCR_ENABLE_BIT];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ier_q <= REG_RESET;
      lcr_q <= REG_RESET;
      mcr_q <= REG_RESET;
      fcr_q <= REG_RESET;
      scr_q <= REG_RESET;
      hs_q  <= 1'b0;
    end else if (wr) begin
      case (idx)
        REG_IER:     if (!divisor_access_bit) ier_q <= {4'h0, wdat[3:0]};
        REG_IIR_FCR: fcr_q <= {wdat[7:6], 2'b00, wdat[3], 2'b00, wdat[0]};
        REG_LCR:     lcr_q <= wdat;
        REG_MCR:     mcr_q <= {3'b000, wdat[4:0]};
        REG_SCR:     scr_q <= wdat;
        REG_XCTL:    hs_q <= wdat[0];
        default:     ;
      endcase
    end
  end

  // Frame geometry: start + data + parity + stops, in 16x ticks
  logic [3:0] nbits, char_bits;
  logic [7:0] char_ticks;
  logic [9:0] to_limit;
  assign nbits      = 4'h5 + {2'b00, lcr_q[1:0]};
  assign char_bits  = nbits + 4'h2 + {3'b000, lcr_q[LCR_PEN_BIT]} + {3'b000, lcr_q[LCR_STB_BIT]};
  assign char_ticks = {char_bits, 4'h0};
  assign to_limit   = {char_ticks, 2'b00} << (TIMEOUT_CHARS - 2'h2);

  logic par_bit;
  logic loop_en;
  assign loop_en = mcr_q[MCR_LOOP_BIT];

  // Receive FIFO; also one deep in non-FIFO mode
  rx_entry_type rx_mem [FIFO_DEPTH];
  logic [3:0]   rx_wp_q, rx_rp_q;
  logic [4:0]   rx_cnt_q;
  logic         rx_push, rx_pop, rx_full, rx_clr;
  rx_entry_type rx_new, rx_head;
  assign rx_full = (rx_cnt_q == (fifo_en ? FIFO_FULL : 5'h01));
  assign rx_pop  = rd_rbr & (rx_cnt_q != 5'h00);
  // Clear on reset bit or on any change of FIFO enable
  assign rx_clr  = wr_fcr & (wdat[FCR_RXCLR_BIT] | (wdat[FCR_ENABLE_BIT] != fifo_en));
  assign rx_head = rx_mem[rx_rp_q];
  always_ff @(posedge clk_i) begin
    if (rx_push & ~rx_full) rx_mem[rx_wp_q] <= rx_new;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i | rx_clr) begin
      rx_wp_q  <= 4'h0;
      rx_rp_q  <= 4'h0;
      rx_cnt_q <= 5'h00;
    end else begin
      if (rx_push & ~rx_full) rx_wp_q <= rx_wp_q + 4'h1;
      if (rx_pop) rx_rp_q <= rx_rp_q + 4'h1;
      rx_cnt_q <= rx_cnt_q + {4'h0, rx_push & ~rx_full} - {4'h0, rx_pop};
    end
  end

  // Errors anywhere in the receive FIFO
  logic [FIFO_DEPTH-1:0] ent_err;
  genvar gi;
  generate
    for (gi = 0; gi < FIFO_DEPTH; gi++) begin : g_err
      logic [3:0] off;
      assign off = 4'(gi) - rx_rp_q;
      assign ent_err[gi] = ({1'b0, off} < rx_cnt_q) &
                           (rx_mem[gi].brk | rx_mem[gi].frame_err | rx_mem[gi].parity_err);
    end
  endgenerate

  // Receiver
  serial_state_type rs_q;
  logic [3:0] rtk_q, rbit_q;
  logic [7:0] rsh_q;
  logic       rpar_q, rx_line;
  logic       serial_out_int;
  assign rx_line = loop_en ? serial_out_int : sync2_q[0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rs_q    <= ST_IDLE;
      rtk_q   <= 4'h0;
      rbit_q  <= 4'h0;
      rsh_q   <= 8'h00;
      rpar_q  <= 1'b0;
      rx_push <= 1'b0;
      rx_new  <= '0;
    end else begin
      rx_push <= 1'b0;
      if (rs_q == ST_IDLE) begin
        rtk_q <= 4'h0;
        if (!rx_line) rs_q <= ST_START;
      end else if (tick16) begin
        rtk_q <= rtk_q + 4'h1;
        case (rs_q)
          ST_START: if (rtk_q == START_MID) begin
            rtk_q  <= 4'h0;
            rbit_q <= 4'h0;
            rsh_q  <= 8'h00;
            rs_q   <= rx_line ? ST_IDLE : ST_DATA;
          end
          ST_DATA: if (rtk_q == TICKS_PER_BIT) begin
            rsh_q[rbit_q[2:0]] <= rx_line;
            rbit_q <= rbit_q + 4'h1;
            if (rbit_q == nbits - 4'h1) rs_q <= lcr_q[LCR_PEN_BIT] ? ST_PARITY : ST_STOP;
          end
          ST_PARITY: if (rtk_q == TICKS_PER_BIT) begin
            rpar_q <= rx_line;
            rs_q   <= ST_STOP;
          end
          ST_STOP: if (rtk_q == TICKS_PER_BIT) begin
            rx_new.data       <= rsh_q;
            rx_new.frame_err  <= ~rx_line;
            rx_new.parity_err <= lcr_q[LCR_PEN_BIT] & (rpar_q != par_bit);
            rx_new.brk        <= ~rx_line & (rsh_q == 8'h00) & ~rpar_q;
            rx_push           <= 1'b1;
            rs_q              <= ST_IDLE;
          end
          default: rs_q <= ST_IDLE;
        endcase
      end
    end
  end
  // Expected parity of the received word
  assign par_bit = lcr_q[LCR_STICK_BIT] ? ~lcr_q[LCR_EPS_BIT] : (^rsh_q) ^ ~lcr_q[LCR_EPS_BIT];

  // Line status: sticky error bits, set wins over the read clear
  logic [3:0] lerr_q;  // {brk, fe, pe, oe}
  logic       head_new;
  assign head_new = (rx_pop & (rx_cnt_q > 5'h01)) | (rx_push & ~rx_full & (rx_cnt_q == 5'h00));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lerr_q <= 4'h0;
    end else begin
      logic [3:0] set;
      set = 4'h0;
      set[0] = rx_push & rx_full;
      if (head_new) begin
        set[3:1] = rx_pop ? {rx_mem[rx_rp_q + 4'h1].brk, rx_mem[rx_rp_q + 4'h1].frame_err,
                             rx_mem[rx_rp_q + 4'h1].parity_err}
                          : {rx_new.brk, rx_new.frame_err, rx_new.parity_err};
      end
      lerr_q <= (rd_lsr ? 4'h0 : lerr_q) | set;
    end
  end

  // Character time-out
  logic [9:0] to_cnt_q;
  logic       to_q;
  always_ff @(posedge clk_i) begin
    if (rst_i | rx_clr) begin
      to_cnt_q <= 10'h000;
      to_q     <= 1'b0;
    end else if (rx_pop | rx_push) begin
      to_cnt_q <= 10'h000;
      to_q     <= 1'b0;
    end else if (!fifo_en || rx_cnt_q == 5'h00) begin
      to_cnt_q <= 10'h000;
      to_q     <= 1'b0;
    end else if (tick16 && !to_q) begin
      to_cnt_q <= to_cnt_q + 10'h001;
      if (to_cnt_q + 10'h001 >= to_limit) to_q <= 1'b1;
    end
  end

  // Transmit FIFO
  logic [7:0] tx_mem [FIFO_DEPTH];
  logic [3:0] tx_wp_q, tx_rp_q;
  logic [4:0] tx_cnt_q;
  logic       tx_pop, tx_clr, tx_push;
  assign tx_clr  = wr_fcr & (wdat[FCR_TXCLR_BIT] | (wdat[FCR_ENABLE_BIT] != fifo_en));
  assign tx_push = wr_thr & (tx_cnt_q != (fifo_en ? FIFO_FULL : 5'h01));
  always_ff @(posedge clk_i) begin
    if (tx_push) tx_mem[tx_wp_q] <= wdat;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i | tx_clr) begin
      tx_wp_q  <= 4'h0;
      tx_rp_q  <= 4'h0;
      tx_cnt_q <= 5'h00;
    end else begin
      if (tx_push) tx_wp_q <= tx_wp_q + 4'h1;
      if (tx_pop) tx_rp_q <= tx_rp_q + 4'h1;
      tx_cnt_q <= tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
    end
  end

  // Transmitter
  serial_state_type ts_q;
  logic [3:0] ttk_q, tbit_q;
  logic [7:0] tsh_q;
  logic       tpar_q, tline_q, tstop2_q;
  assign tx_pop = (ts_q == ST_IDLE) & (tx_cnt_q != 5'h00);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ts_q     <= ST_IDLE;
      ttk_q    <= 4'h0;
      tbit_q   <= 4'h0;
      tsh_q    <= 8'h00;
      tpar_q   <= 1'b0;
      tline_q  <= 1'b1;
      tstop2_q <= 1'b0;
    end else begin
      case (ts_q)
        ST_IDLE: begin
          tline_q <= 1'b1;
          if (tx_pop) begin
            tsh_q   <= tx_mem[tx_rp_q];
            tpar_q  <= lcr_q[LCR_STICK_BIT] ? ~lcr_q[LCR_EPS_BIT] : (^tx_mem[tx_rp_q]) ^ ~lcr_q[LCR_EPS_BIT];
            ttk_q   <= 4'h0;
            tbit_q  <= 4'h0;
            tline_q <= 1'b0;
            ts_q    <= ST_START;
          end
        end
        default: if (tick16) begin
          ttk_q <= ttk_q + 4'h1;
          if (ttk_q == TICKS_PER_BIT) begin
            case (ts_q)
              ST_START: begin
                ts_q    <= ST_DATA;
                tline_q <= tsh_q[0];
              end
              ST_DATA: begin
                tbit_q <= tbit_q + 4'h1;
                if (tbit_q == nbits - 4'h1) begin
                  ts_q     <= lcr_q[LCR_PEN_BIT] ? ST_PARITY : ST_STOP;
                  tline_q  <= lcr_q[LCR_PEN_BIT] ? tpar_q : 1'b1;
                  tstop2_q <= lcr_q[LCR_STB_BIT];
                end else begin
                  tline_q <= tsh_q[3'(tbit_q + 4'h1)];
                end
              end
              ST_PARITY: begin
                ts_q    <= ST_STOP;
                tline_q <= 1'b1;
              end
              default: begin
                if (tstop2_q) tstop2_q <= 1'b0;
                else ts_q <= ST_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end
  assign serial_out_int   = tline_q & ~lcr_q[LCR_BREAK_BIT];
  // Loopback holds the pin marking and keeps modem outputs inactive
  assign serial_out_ch1_o = serial_out_int | loop_en;

  // Transmit empty interrupt with the short-burst delay
  logic       transmit_holding_empty_q, two_seen_q, dly_on_q, tx_empty_q;
  logic [7:0] dly_q;
  logic       tx_empty;
  // Priority decode results, driven further down with the interrupt logic
  logic       irq_pend;
  logic [2:0] iir_id;
  assign tx_empty = (tx_cnt_q == 5'h00);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transmit_holding_empty_q     <= 1'b0;
      two_seen_q <= 1'b0;
      dly_on_q   <= 1'b0;
      dly_q      <= 8'h00;
      tx_empty_q <= 1'b1;
    end else begin
      logic transmit_holding_empty_set;
      logic transmit_holding_empty_clr;
      transmit_holding_empty_set = 1'b0;
      transmit_holding_empty_clr = 1'b0;
      tx_empty_q <= tx_empty;
      if (tx_cnt_q >= 5'h02) two_seen_q <= 1'b1;
      if (tx_empty & ~tx_empty_q) begin
        if (two_seen_q || !fifo_en) transmit_holding_empty_set = 1'b1;
        else begin
          dly_on_q <= 1'b1;
          dly_q    <= 8'h00;
        end
      end
      if (dly_on_q) begin
        if (!tx_empty) dly_on_q <= 1'b0;
        else if (tick16) begin
          dly_q <= dly_q + 8'h01;
          if (dly_q + 8'h01 >= char_ticks - 8'h10) begin
            dly_on_q <= 1'b0;
            transmit_holding_empty_set = 1'b1;
          end
        end
      end
      if (wr_fcr && wdat[FCR_ENABLE_BIT] != fifo_en) begin
        dly_on_q <= 1'b0;
        transmit_holding_empty_set = 1'b1;
      end
      if (wr && idx == REG_IER && !divisor_access_bit && wdat[1] && !ier_q[1] && tx_empty) transmit_holding_empty_set = 1'b1;
      transmit_holding_empty_clr = wr_thr | (rd_iir & (iir_id == ID_TRANSMIT_HOLDING_EMPTY) & irq_pend);
      if (transmit_holding_empty_set) two_seen_q <= 1'b0;
      transmit_holding_empty_q <= transmit_holding_empty_set | (transmit_holding_empty_q & ~transmit_holding_empty_clr);
    end
  end

  // Modem status
  logic [3:0] mst, mst_q, dlt_q;  // {dcd, ri, dsr, cts}
  assign mst = loop_en ? {mcr_q[3], mcr_q[2], mcr_q[0], mcr_q[1]} : ~sync2_q[4:1];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mst_q <= 4'h0;
      dlt_q <= 4'h0;
    end else begin
      mst_q <= mst;
      dlt_q <= (rd_msr ? 4'h0 : dlt_q) |
               {mst[3] ^ mst_q[3], ~mst[2] & mst_q[2], mst[1] ^ mst_q[1], mst[0] ^ mst_q[0]};
    end
  end
  assign request_send_n_o    = ~mcr_q[1] | loop_en;
  assign terminal_ready_n_o  = ~mcr_q[0] | loop_en;
  assign user_output_one_n_o = ~mcr_q[2] | loop_en;
  assign user_output_two_n_o = ~mcr_q[3] | loop_en;

  // Interrupt priority
  logic [4:0] trig;
  logic       ls_int, rda_int, to_int, transmit_holding_empty_int, ms_int;
  always_comb begin
    case (fcr_q[7:6])
      2'h0:    trig = TRIG_0;
      2'h1:    trig = TRIG_1;
      2'h2:    trig = TRIG_2;
      default: trig = TRIG_3;
    endcase
    if (!fifo_en) trig = TRIG_0;
  end
  assign ls_int   = ier_q[2] & (|lerr_q);
  assign rda_int  = ier_q[0] & (rx_cnt_q >= trig);
  assign to_int   = ier_q[0] & to_q;
  assign transmit_holding_empty_int = ier_q[1] & transmit_holding_empty_q;
  assign ms_int   = ier_q[3] & (|dlt_q);
  assign irq_pend = ls_int | rda_int | to_int | transmit_holding_empty_int | ms_int;
  always_comb begin
    if (ls_int) iir_id = ID_LINE;
    else if (rda_int) iir_id = ID_RXDATA;
    else if (to_int) iir_id = ID_TIMEOUT;
    else if (transmit_holding_empty_int) iir_id = ID_TRANSMIT_HOLDING_EMPTY;
    else iir_id = ID_MODEM;
  end
  assign channel_interrupt_o = irq_pend;

  // Status views
  logic [7:0] line_status_reg, msr, interrupt_ident_reg;
  assign line_status_reg = {|ent_err, tx_empty & (ts_q == ST_IDLE), tx_empty, lerr_q[3:1], lerr_q[0],
                rx_cnt_q != 5'h00};
  assign msr = {mst, dlt_q};
  assign interrupt_ident_reg = {fifo_en, fifo_en, 2'b00, irq_pend ? iir_id : 3'h0, ~irq_pend};

  // Bus answer: acknowledge one cycle after the request, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q    <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (rd) begin
        case (idx)
          REG_DATA:    wb_dat_o <= {24'h0, divisor_access_bit ? div_q[7:0] : rx_head.data};
          REG_IER:     wb_dat_o <= {24'h0, divisor_access_bit ? div_q[15:8] : ier_q};
          REG_IIR_FCR: wb_dat_o <= {24'h0, interrupt_ident_reg};
          REG_LCR:     wb_dat_o <= {24'h0, lcr_q};
          REG_MCR:     wb_dat_o <= {24'h0, mcr_q};
          REG_LSR:     wb_dat_o <= {24'h0, line_status_reg};
          REG_MSR:     wb_dat_o <= {24'h0, msr};
          REG_SCR:     wb_dat_o <= {24'h0, scr_q};
          REG_XCTL:    wb_dat_o <= {31'h0, hs_q};
          default:     wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_q;

endmodule

// ### rtl/uart_chan_pkg.sv
package uart_chan_pkg;

  // Register indices; byte address is four times the index
  localparam logic [3:0] REG_DATA     = 4'h0;
  localparam logic [3:0] REG_IER      = 4'h1;
  localparam logic [3:0] REG_IIR_FCR  = 4'h2;
  localparam logic [3:0] REG_LCR      = 4'h3;
  localparam logic [3:0] REG_MCR      = 4'h4;
  localparam logic [3:0] REG_LSR      = 4'h5;
  localparam logic [3:0] REG_MSR      = 4'h6;
  localparam logic [3:0] REG_SCR      = 4'h7;
  localparam logic [3:0] REG_XCTL     = 4'h8;

  // Field positions
  localparam int LCR_DIVISOR_ACCESS_BIT_BIT   = 7;
  localparam int LCR_BREAK_BIT  = 6;
  localparam int LCR_PEN_BIT    = 3;
  localparam int LCR_STB_BIT    = 2;
  localparam int LCR_EPS_BIT    = 4;
  localparam int LCR_STICK_BIT  = 5;
  localparam int MCR_LOOP_BIT   = 4;
  localparam int FCR_ENABLE_BIT = 0;
  localparam int FCR_RXCLR_BIT  = 1;
  localparam int FCR_TXCLR_BIT  = 2;

  // Reset values
  localparam logic [7:0] IIR_RESET = 8'h01;
  localparam logic [7:0] LSR_RESET = 8'h60;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Interrupt identification codes (bits 3:1)
  localparam logic [2:0] ID_LINE    = 3'h3;
  localparam logic [2:0] ID_RXDATA  = 3'h2;
  localparam logic [2:0] ID_TIMEOUT = 3'h6;
  localparam logic [2:0] ID_TRANSMIT_HOLDING_EMPTY    = 3'h1;
  localparam logic [2:0] ID_MODEM   = 3'h0;

  // Receive trigger levels selected by FIFO control bits 7:6
  localparam logic [4:0] TRIG_0 = 5'h01;
  localparam logic [4:0] TRIG_1 = 5'h04;
  localparam logic [4:0] TRIG_2 = 5'h08;
  localparam logic [4:0] TRIG_3 = 5'h0E;

  // Baud generator input and system clock
  localparam longint BRG_IN_FREQ_HZ = 1846200;
  localparam longint CLK_FREQ_HZ    = 250000000;
  localparam int     ACC_W          = 28;
  // Accumulator runs at four times the oscillator rate so the high-speed modes fit
  localparam logic [ACC_W-1:0] ACC_INC = ACC_W'(4 * BRG_IN_FREQ_HZ);
  localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_FREQ_HZ);

  localparam int         FIFO_DEPTH    = 16;
  localparam logic [4:0] FIFO_FULL     = 5'h10;
  localparam logic [3:0] TICKS_PER_BIT = 4'hF;
  localparam logic [3:0] START_MID     = 4'h7;
  localparam logic [1:0] TIMEOUT_CHARS = 2'h2;  // Shift amount: four characters

  typedef struct packed {
    logic       brk;
    logic       frame_err;
    logic       parity_err;
    logic [7:0] data;
  } rx_entry_type;

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP} serial_state_type;

endpackage

// ### testbench/uart_chan_assertions.sv
`timescale 1ns/100ps
module uart_chan_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        serial_out_ch1_o,
  input wire logic        request_send_n_o,
  input wire logic        terminal_ready_n_o,
  input wire logic        user_output_one_n_o,
  input wire logic        user_output_two_n_o,
  input wire logic        baud_out_o,
  input wire logic        channel_interrupt_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence pulse_s; wb_ack_o ##1 !wb_ack_o; endsequence
  // Pins must already sit in the idle state at the first edge after reset
  sequence idle_s;
    serial_out_ch1_o && request_send_n_o && terminal_ready_n_o && user_output_one_n_o && user_output_two_n_o
      && !channel_interrupt_o;
  endsequence
  chk_ack_pulse: assert property (req_s |=> pulse_s) else $error("ack not one pulse after request");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o)) else $error("stray ack");
  chk_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("read data moved without ack");
  chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
  chk_reset_pins: assert property ($fell(rst_i) |-> idle_s) else $error("pins not idle after reset");
  chk_baud_reset: assert property ($fell(rst_i) |-> baud_out_o) else $error("baud output low after reset");
  chk_baud_low: assert property ($fell(baud_out_o) |-> ##[1:400] baud_out_o) else $error("baud low too long");
  chk_baud_high: assert property ($rose(baud_out_o) |-> ##[1:1000] !baud_out_o) else $error("baud stuck high");
endmodule

bind uart_chan uart_chan_checker u_uart_chan_checker (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .serial_out_ch1_o, .request_send_n_o,
  .terminal_ready_n_o, .user_output_one_n_o, .user_output_two_n_o, .baud_out_o, .channel_interrupt_o
);

// ### testbench/serial_peer.sv
`timescale 1ns/100ps
module serial_peer #(
  parameter int BIT_CLK = 543
) (
  input  wire logic       clk_i,
  output logic            line_o,
  output logic [3:0]      modem_n_o
);
  initial begin
    line_o    = 1'b1;
    modem_n_o = 4'hF;
  end
  // 8N1 frame, LSB first; the line rests at mark between frames
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      line_o <= f[i];
      repeat (BIT_CLK - 1) @(posedge clk_i);
    end
  endtask
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import uart_chan_pkg::*;
;
  logic        clk_i, rst_i, cyc, stb, we, ack, sout, rts_n, dtr_n, o1_n, o2_n, baud, irq, sin;
  logic [5:0]  adr;
  logic [3:0]  sel, mdm;
  logic [31:0] wdat, rdat;
  logic [7:0]  q;
  int          n_fail, checks;
  real         p;

  uart_chan u_uart_chan (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .serial_in_i(sin),
    .clear_send_n_i(mdm[0]), .set_ready_n_i(mdm[1]), .ring_n_i(mdm[2]), .carrier_n_i(mdm[3]),
    .serial_out_ch1_o(sout), .request_send_n_o(rts_n), .terminal_ready_n_o(dtr_n),
    .user_output_one_n_o(o1_n), .user_output_two_n_o(o2_n), .baud_out_o(baud), .channel_interrupt_o(irq));
  serial_peer u_serial_peer (.clk_i(clk_i), .line_o(sin), .modem_n_o(mdm));

  task automatic end_of_test;
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    sel <= 4'hF;
    wdat <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    chk(q, e);
  endtask
  // Two edges let a registered flag settle before the pin is judged
  task automatic irqchk(input logic e);
    repeat (2) @(posedge clk_i);
    chk({7'h0, irq}, {7'h0, e});
  endtask
  task automatic set_div(input logic [15:0] dv);
    bus(1'b1, REG_LCR, 8'h80);
    bus(1'b1, REG_DATA, dv[7:0]);
    bus(1'b1, REG_IER, dv[15:8]);
    bus(1'b1, REG_LCR, 8'h03);
  endtask
  task automatic baudchk(input logic [15:0] dv, input int l, input int h);
    int lo, hi, e;
    set_div(dv);
    repeat (2) @(posedge baud);
    lo = 0;
    hi = 0;
    while (baud) begin @(posedge clk_i); hi++; end
    while (!baud) begin @(posedge clk_i); lo++; end
    e = $rtoi(p * (l + h));
    chk(8'(lo + hi > e - 3 && lo + hi < e + 3), 8'h01);
    if (h != 0) chk(8'(hi > $rtoi(p * h) - 3 && hi < $rtoi(p * h) + 3), 8'h01);
    $display("baud divisor %h done", dv);
  endtask

  task automatic t_reset;
    chk({3'h0, sout, rts_n, dtr_n, o1_n, o2_n}, 8'h1F);
    irqchk(1'b0);
    rdchk(REG_IER, REG_RESET);
    rdchk(REG_IIR_FCR, IIR_RESET);
    rdchk(REG_LCR, REG_RESET);
    rdchk(REG_MCR, REG_RESET);
    rdchk(REG_LSR, LSR_RESET);
    rdchk(REG_MSR, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_regs;
    bus(1'b1, REG_IER, 8'h05);
    set_div(16'h0002);
    bus(1'b1, REG_LCR, 8'h80);
    rdchk(REG_DATA, 8'h02);
    rdchk(REG_IER, 8'h00);
    bus(1'b1, REG_LCR, 8'h03);
    rdchk(REG_IER, 8'h05);
    bus(1'b1, 4'hF, 8'hFF);
    rdchk(4'hF, 8'h00);
    bus(1'b1, REG_IER, 8'h00);
    $display("register test done");
  endtask
  task automatic t_tx;
    bus(1'b1, REG_IER, 8'h02);
    irqchk(1'b1);
    rdchk(REG_IIR_FCR, {4'h0, ID_TRANSMIT_HOLDING_EMPTY, 1'b0});
    irqchk(1'b0);
    bus(1'b1, REG_IIR_FCR, 8'h41);
    irqchk(1'b1);
    rdchk(REG_IIR_FCR, {4'hC, ID_TRANSMIT_HOLDING_EMPTY, 1'b0});
    irqchk(1'b0);
    bus(1'b1, REG_IER, 8'h00);
    $display("transmit interrupt test done");
  endtask
  task automatic t_rx;
    bus(1'b1, REG_XCTL, 8'h01);
    set_div(16'h8001);
    bus(1'b1, REG_IER, 8'h01);
    for (int i = 0; i < 4; i++) begin
      u_serial_peer.send(8'hA0 + 8'(i));
      if (i == 0) rdchk(REG_LSR, 8'h61);
    end
    irqchk(1'b1);
    rdchk(REG_IIR_FCR, {4'hC, ID_RXDATA, 1'b0});
    rdchk(REG_DATA, 8'hA0);
    irqchk(1'b0);
    repeat (16000) @(posedge clk_i);
    irqchk(1'b0);
    for (int n = 0; n < 12000 && irq !== 1'b1; n++) @(posedge clk_i);
    rdchk(REG_IIR_FCR, {4'hC, ID_TIMEOUT, 1'b0});
    rdchk(REG_DATA, 8'hA1);
    irqchk(1'b0);
    $display("receive test done");
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    n_fail++;
    end_of_test;
  end
  initial begin
    {rst_i, cyc, stb, we, adr, sel, wdat, q, n_fail, checks} = '0;
    rst_i = 1'b1;
    p = real'(CLK_FREQ_HZ) / real'(BRG_IN_FREQ_HZ);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    t_reset;
    t_regs;
    baudchk(16'h0002, 1, 1);
    baudchk(16'h0000, 2, 1);
    baudchk(16'h0005, 2, 3);
    baudchk(16'h0001, 1, 0);
    t_tx;
    t_rx;
    end_of_test;
  end
endmodule
